// ==== shared/hwil_pkg.sv ====
// Constants for the low hardware interrupt register set
package hwil_pkg;
  // Bit positions shared by pending, enable and output-enable registers
  localparam int unsigned HWIL_BIT_CTL_WRAP = 9;
  localparam int unsigned HWIL_BIT_TERM2_MATCH = 8;
  localparam int unsigned HWIL_BIT_TERM1_MATCH = 7;
  localparam int unsigned HWIL_BIT_MON_MATCH = 6;
  localparam int unsigned HWIL_BIT_CTL_MATCH = 5;
  localparam int unsigned HWIL_BIT_TERM2_APF = 4;
  localparam int unsigned HWIL_BIT_TERM1_APF = 3;
  localparam int unsigned HWIL_BIT_TERM_SUM = 2;
  localparam int unsigned HWIL_BIT_MON_SUM = 1;
  localparam int unsigned HWIL_BIT_CTL_SUM = 0;

  // Writable event bits 9..3; 15..10 read zero, 2..0 read zero except in pending, where they are the summaries
  localparam logic [15:0] HWIL_EVENT_MASK = 16'h03F8;

  // Reset values
  localparam logic [15:0] HWIL_PEND_RST = 16'h0018;
  localparam logic [15:0] HWIL_EN_RST = 16'h0018;
  localparam logic [15:0] HWIL_OEN_RST = 16'h0000;

  // Register select codes on the host register port
  localparam logic [1:0] HWIL_REG_PEND = 2'h0;
  localparam logic [1:0] HWIL_REG_EN = 2'h1;
  localparam logic [1:0] HWIL_REG_OEN = 2'h2;

  // Widths
  localparam int unsigned HWIL_REG_W = 16;
  localparam int unsigned HWIL_RT_TAG_W = 16;
  localparam int unsigned HWIL_BC_TAG_W = 32;
  localparam int unsigned HWIL_MT_TAG_W = 48;
  localparam int unsigned HWIL_ADDR_W = 6;

  // Count masks for the narrow counter options and the fixed 16-bit terminal counters
  localparam logic [31:0] HWIL_BC_NARROW_MASK = 32'h0000FFFF;
  localparam logic [47:0] HWIL_MT_NARROW_MASK = 48'h00000000FFFF;
  localparam logic [15:0] HWIL_RT_MASK = 16'hFFFF;
endpackage : hwil_pkg

// ==== rtl/hwil_tag_event.sv ====
// Time tag match and wrap detector for one counter
`timescale 1ns/100ps
module hwil_tag_event #(
  parameter int unsigned W = 16
) (
  // Counter after increment
  input wire logic tick,
  input wire logic [W-1:0] count,
  // Match value and active width
  input wire logic [W-1:0] match,
  input wire logic [W-1:0] width_mask,
  // Events, same cycle as tick
  output logic hit,
  output logic wrap
);
  // Only the compared width counts; upper bits ignored in narrow mode
  assign hit = tick && (((count ^ match) & width_mask) == '0);
  assign wrap = tick && ((count & width_mask) == '0);
endmodule : hwil_tag_event

// ==== rtl/hwil_addr_capture.sv ====
// Terminal address capture and parity check at master reset release
`timescale 1ns/100ps
module hwil_addr_capture (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Master reset rising edge, already synchronised
  input wire logic mr_rise,
  // Terminal pins, asynchronous
  input wire logic enable_pin,
  input wire logic [hwil_pkg::HWIL_ADDR_W-1:0] addr_pins,
  // Results
  output logic [hwil_pkg::HWIL_ADDR_W-1:0] op_status,
  output logic parity_fail,
  output logic cap_done
);
  localparam int unsigned N = hwil_pkg::HWIL_ADDR_W + 1;

  logic [N-1:0] pin_in;
  logic [N-1:0] stable;
  logic [hwil_pkg::HWIL_ADDR_W-1:0] status_r, status_nxt;
  logic fail_r, fail_nxt;
  logic done_r, done_nxt;

  assign pin_in = {enable_pin, addr_pins};

  // Three-stage sync; a change counts when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sync
      logic [2:0] s_r;
      logic hold_r;
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          s_r <= 3'h0;
          hold_r <= 1'b0;
        end else begin
          s_r <= {s_r[1:0], pin_in[i]};
          hold_r <= (s_r[1] == s_r[2]) ? s_r[2] : hold_r;
        end
      end
      assign stable[i] = hold_r;
    end
  endgenerate

  always_comb begin
    status_nxt = status_r;
    fail_nxt = fail_r;
    done_nxt = 1'b0;
    if (mr_rise) begin
      status_nxt = stable[hwil_pkg::HWIL_ADDR_W-1:0];
      // Even count of ones fails odd parity; checked only when enabled
      fail_nxt = stable[N-1] && !(^stable[hwil_pkg::HWIL_ADDR_W-1:0]);
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
      fail_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      fail_r <= fail_nxt;
      done_r <= done_nxt;
    end
  end

  assign op_status = status_r;
  assign parity_fail = fail_r;
  assign cap_done = done_r;

  a_disabled_no_fail: assert property (@(posedge clk_sys) disable iff (!arst_n)
    mr_rise && !stable[N-1] |=> !parity_fail)
    else $error("parity failure flagged for a disabled terminal");
  a_odd_parity_pass: assert property (@(posedge clk_sys) disable iff (!arst_n)
    mr_rise && (^stable[hwil_pkg::HWIL_ADDR_W-1:0]) |=> cap_done && !parity_fail)
    else $error("odd parity address flagged as failure");
endmodule : hwil_addr_capture

// ==== rtl/hwil_top.sv ====
// Low hardware interrupt registers: pending, enable, output enable
`timescale 1ns/100ps
module hwil_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Host register port
  input wire logic [1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rd_valid,
  // Controller time tag
  input wire logic bc_tag_tick,
  input wire logic bc_tag_wide,
  input wire logic [hwil_pkg::HWIL_BC_TAG_W-1:0] bc_tag_count,
  input wire logic [hwil_pkg::HWIL_BC_TAG_W-1:0] bc_tag_match,
  // Monitor time tag
  input wire logic mt_tag_tick,
  input wire logic mt_tag_wide,
  input wire logic [hwil_pkg::HWIL_MT_TAG_W-1:0] mt_tag_count,
  input wire logic [hwil_pkg::HWIL_MT_TAG_W-1:0] mt_tag_match,
  // Terminal one time tag
  input wire logic rt1_tag_tick,
  input wire logic [hwil_pkg::HWIL_RT_TAG_W-1:0] rt1_tag_count,
  input wire logic [hwil_pkg::HWIL_RT_TAG_W-1:0] rt1_tag_match,
  // Terminal two time tag
  input wire logic rt2_tag_tick,
  input wire logic [hwil_pkg::HWIL_RT_TAG_W-1:0] rt2_tag_count,
  input wire logic [hwil_pkg::HWIL_RT_TAG_W-1:0] rt2_tag_match,
  // Per-function pending registers
  input wire logic [15:0] bc_pend_reg,
  input wire logic [15:0] mt_pend_reg,
  input wire logic [15:0] rt_pend_reg,
  // Pins
  input wire logic master_reset_pin,
  input wire logic term_one_enable_pin,
  input wire logic term_two_enable_pin,
  input wire logic [hwil_pkg::HWIL_ADDR_W-1:0] term_one_addr_pins,
  input wire logic [hwil_pkg::HWIL_ADDR_W-1:0] term_two_addr_pins,
  // Outputs
  output logic hw_int_out,
  output logic [hwil_pkg::HWIL_ADDR_W-1:0] term_one_op_status,
  output logic [hwil_pkg::HWIL_ADDR_W-1:0] term_two_op_status
);
  // Master reset pin sync and release detect
  logic [2:0] mr_s_r, mr_s_nxt;
  logic mr_hold_r, mr_hold_nxt;
  logic mr_rise;

  // Register state
  logic [15:0] pend_r, pend_nxt;
  logic [15:0] en_r, en_nxt;
  logic [15:0] oen_r, oen_nxt;
  logic irq_r, irq_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic rd_valid_r, rd_valid_nxt;

  // Event sources
  logic bc_hit, bc_wrap, mt_hit, rt1_hit, rt2_hit;
  logic t1_fail, t1_done, t2_fail, t2_done;
  logic [15:0] ev_vec, set_vec, pend_view;
  logic controller_summary_pending;
  logic monitor_summary_pending;
  logic terminal_summary_pending;
  logic [hwil_pkg::HWIL_BC_TAG_W-1:0] bc_mask;
  logic [hwil_pkg::HWIL_MT_TAG_W-1:0] mt_mask;

  assign bc_mask = bc_tag_wide ? '1 : hwil_pkg::HWIL_BC_NARROW_MASK;
  assign mt_mask = mt_tag_wide ? '1 : hwil_pkg::HWIL_MT_NARROW_MASK;

  hwil_tag_event #(.W(hwil_pkg::HWIL_BC_TAG_W)) u_bc_tag (
    .tick(bc_tag_tick),
    .count(bc_tag_count),
    .match(bc_tag_match),
    .width_mask(bc_mask),
    .hit(bc_hit),
    .wrap(bc_wrap)
  );

  hwil_tag_event #(.W(hwil_pkg::HWIL_MT_TAG_W)) u_mt_tag (
    .tick(mt_tag_tick),
    .count(mt_tag_count),
    .match(mt_tag_match),
    .width_mask(mt_mask),
    .hit(mt_hit),
    .wrap()
  );

  hwil_tag_event #(.W(hwil_pkg::HWIL_RT_TAG_W)) u_rt1_tag (
    .tick(rt1_tag_tick),
    .count(rt1_tag_count),
    .match(rt1_tag_match),
    .width_mask(hwil_pkg::HWIL_RT_MASK),
    .hit(rt1_hit),
    .wrap()
  );

  hwil_tag_event #(.W(hwil_pkg::HWIL_RT_TAG_W)) u_rt2_tag (
    .tick(rt2_tag_tick),
    .count(rt2_tag_count),
    .match(rt2_tag_match),
    .width_mask(hwil_pkg::HWIL_RT_MASK),
    .hit(rt2_hit),
    .wrap()
  );

  // Pin edge only counts once stages two and three agree
  always_comb begin
    mr_s_nxt = {mr_s_r[1:0], master_reset_pin};
    mr_hold_nxt = (mr_s_r[1] == mr_s_r[2]) ? mr_s_r[2] : mr_hold_r;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mr_s_r <= 3'h0;
      mr_hold_r <= 1'b0;
    end else begin
      mr_s_r <= mr_s_nxt;
      mr_hold_r <= mr_hold_nxt;
    end
  end

  assign mr_rise = (mr_s_r[1] == mr_s_r[2]) && mr_s_r[2] && !mr_hold_r;

  hwil_addr_capture u_term_one (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .mr_rise(mr_rise),
    .enable_pin(term_one_enable_pin),
    .addr_pins(term_one_addr_pins),
    .op_status(term_one_op_status),
    .parity_fail(t1_fail),
    .cap_done(t1_done)
  );

  hwil_addr_capture u_term_two (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .mr_rise(mr_rise),
    .enable_pin(term_two_enable_pin),
    .addr_pins(term_two_addr_pins),
    .op_status(term_two_op_status),
    .parity_fail(t2_fail),
    .cap_done(t2_done)
  );

  // Summaries follow the per-function registers live, never stored
  assign terminal_summary_pending = |rt_pend_reg;
  assign monitor_summary_pending = |mt_pend_reg;
  assign controller_summary_pending = |bc_pend_reg;

  always_comb begin
    ev_vec = 16'h0000;
    ev_vec[hwil_pkg::HWIL_BIT_CTL_WRAP] = bc_wrap;
    ev_vec[hwil_pkg::HWIL_BIT_TERM2_MATCH] = rt2_hit;
    ev_vec[hwil_pkg::HWIL_BIT_TERM1_MATCH] = rt1_hit;
    ev_vec[hwil_pkg::HWIL_BIT_MON_MATCH] = mt_hit;
    ev_vec[hwil_pkg::HWIL_BIT_CTL_MATCH] = bc_hit;
  end

  assign set_vec = ev_vec & en_r;

  always_comb begin
    pend_view = pend_r & hwil_pkg::HWIL_EVENT_MASK;
    pend_view[hwil_pkg::HWIL_BIT_TERM_SUM] = terminal_summary_pending;
    pend_view[hwil_pkg::HWIL_BIT_MON_SUM] = monitor_summary_pending;
    pend_view[hwil_pkg::HWIL_BIT_CTL_SUM] = controller_summary_pending;
  end

  // Write-one clears; a set in the same cycle wins over the clear
  always_comb begin
    pend_nxt = pend_r;
    en_nxt = en_r;
    oen_nxt = oen_r;
    if (reg_wr && reg_sel == hwil_pkg::HWIL_REG_PEND) begin
      pend_nxt = pend_r & ~(reg_wdata & hwil_pkg::HWIL_EVENT_MASK);
    end
    if (reg_wr && reg_sel == hwil_pkg::HWIL_REG_EN) begin
      en_nxt = reg_wdata & hwil_pkg::HWIL_EVENT_MASK;
    end
    if (reg_wr && reg_sel == hwil_pkg::HWIL_REG_OEN) begin
      oen_nxt = reg_wdata & hwil_pkg::HWIL_EVENT_MASK;
    end
    pend_nxt = pend_nxt | set_vec;
    // Parity verdict replaces the bit at each master reset release
    if (t1_done) begin
      pend_nxt[hwil_pkg::HWIL_BIT_TERM1_APF] =
        t1_fail && en_r[hwil_pkg::HWIL_BIT_TERM1_APF];
    end
    if (t2_done) begin
      pend_nxt[hwil_pkg::HWIL_BIT_TERM2_APF] =
        t2_fail && en_r[hwil_pkg::HWIL_BIT_TERM2_APF];
    end
    // Pin tracks the registered pending bits with no extra lag
    irq_nxt = |(pend_nxt & oen_nxt & hwil_pkg::HWIL_EVENT_MASK);
  end

  always_comb begin
    rd_valid_nxt = reg_rd;
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      unique case (reg_sel)
        hwil_pkg::HWIL_REG_PEND: rdata_nxt = pend_view;
        hwil_pkg::HWIL_REG_EN: rdata_nxt = en_r & hwil_pkg::HWIL_EVENT_MASK;
        hwil_pkg::HWIL_REG_OEN: rdata_nxt = oen_r & hwil_pkg::HWIL_EVENT_MASK;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= hwil_pkg::HWIL_PEND_RST;
      en_r <= hwil_pkg::HWIL_EN_RST;
      oen_r <= hwil_pkg::HWIL_OEN_RST;
      irq_r <= 1'b0;
      rdata_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      en_r <= en_nxt;
      oen_r <= oen_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign hw_int_out = irq_r;
  assign reg_rdata = rdata_r;
  assign reg_rd_valid = rd_valid_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_wrap_sets_flag: assert property (
    bc_tag_tick && en_r[9] &&
    (bc_tag_wide ? bc_tag_count == 32'h00000000 : bc_tag_count[15:0] == 16'h0000)
    |=> pend_r[9])
    else $error("controller wrap did not set pending bit 9");
  a_term2_match_flag: assert property (
    rt2_tag_tick && rt2_tag_count == rt2_tag_match && en_r[8] |=> pend_r[8])
    else $error("terminal two match did not set pending bit 8");
  a_term1_match_flag: assert property (
    rt1_tag_tick && rt1_tag_count == rt1_tag_match && en_r[7] |=> pend_r[7])
    else $error("terminal one match did not set pending bit 7");
  a_mon_match_flag: assert property (
    mt_tag_tick && en_r[6] &&
    (mt_tag_wide ? mt_tag_count == mt_tag_match : mt_tag_count[15:0] == mt_tag_match[15:0])
    |=> pend_r[6])
    else $error("monitor match did not set pending bit 6");
  a_ctl_match_flag: assert property (
    bc_tag_tick && en_r[5] &&
    (bc_tag_wide ? bc_tag_count == bc_tag_match : bc_tag_count[15:0] == bc_tag_match[15:0])
    |=> pend_r[5])
    else $error("controller match did not set pending bit 5");
  a_term2_parity_load: assert property (
    t2_done |=> pend_r[4] == ($past(t2_fail) && $past(en_r[4])))
    else $error("terminal two parity verdict not loaded");
  a_term1_parity_load: assert property (
    t1_done |=> pend_r[3] == ($past(t1_fail) && $past(en_r[3])))
    else $error("terminal one parity verdict not loaded");
  a_resv_read_zero: assert property (
    reg_rd && reg_sel != hwil_pkg::HWIL_REG_PEND |=> reg_rd_valid && reg_rdata[2:0] == 3'h0)
    else $error("reserved low bits read nonzero");
  a_term_summary_read: assert property (
    reg_rd && reg_sel == hwil_pkg::HWIL_REG_PEND |=> reg_rdata[2] == $past(|rt_pend_reg))
    else $error("terminal summary bit wrong");
  a_mon_summary_read: assert property (
    reg_rd && reg_sel == hwil_pkg::HWIL_REG_PEND |=> reg_rdata[1] == $past(|mt_pend_reg))
    else $error("monitor summary bit wrong");
  a_ctl_summary_read: assert property (
    reg_rd && reg_sel == hwil_pkg::HWIL_REG_PEND |=> reg_rdata[0] == $past(|bc_pend_reg))
    else $error("controller summary bit wrong");
  a_gate_by_enable: assert property (
    $rose(pend_r[9]) |-> $past(en_r[9]))
    else $error("pending bit 9 set while disabled");
  a_irq_tracks_pend: assert property (
    ##1 hw_int_out == |(pend_r & oen_r))
    else $error("interrupt output disagrees with enabled pending bits");

  c_irq_rise: cover property ($rose(hw_int_out));
  c_parity_fail: cover property (t1_done && t1_fail);
  c_wrap_set: cover property (bc_wrap && en_r[9]);
  c_set_on_clear: cover property (
    reg_wr && reg_sel == hwil_pkg::HWIL_REG_PEND && reg_wdata[5] && set_vec[5]);
endmodule : hwil_top

// ==== test/hwil_host_model.sv ====
// Host processor model driving the interrupt register port
`timescale 1ns/100ps
module hwil_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [1:0] reg_sel,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rd_valid
);
  initial begin
    reg_sel = 2'h0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end

  // One write strobe
  task automatic wr(input logic [1:0] sel, input logic [15:0] data);
    @(posedge clk_sys);
    reg_sel <= sel;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // Released data bus must not keep the last word
    reg_wdata <= ~data;
  endtask : wr

  // Summary bits tell the host which function register to read next
  task automatic rd(input logic [1:0] sel, output logic [15:0] data, output bit ok);
    ok = 1'b0;
    data = 16'h0000;
    @(posedge clk_sys);
    reg_sel <= sel;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // Bounded wait, a missing answer is reported by the caller
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (reg_rd_valid === 1'b1) begin
        ok = 1'b1;
        data = reg_rdata;
      end else begin
        @(posedge clk_sys);
      end
    end
  endtask : rd
endmodule : hwil_host_model

// ==== test/hwil_top_tb.sv ====
// Self-checking bench for the low hardware interrupt registers
`timescale 1ns/100ps
`define CHK(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[FAIL] %s expected %h seen %h", name, exp, got); \
    end \
  end
module hwil_top_tb;
  logic clk_sys, arst_n, reg_wr, reg_rd, reg_rd_valid, hw_int_out;
  logic [1:0] reg_sel;
  logic [15:0] reg_wdata, reg_rdata, bc_pend_reg, mt_pend_reg, rt_pend_reg;
  logic bc_tag_tick, bc_tag_wide, mt_tag_tick, mt_tag_wide, rt1_tag_tick, rt2_tag_tick;
  logic [31:0] bc_tag_count, bc_tag_match;
  logic [47:0] mt_tag_count, mt_tag_match;
  logic [15:0] rt1_tag_count, rt1_tag_match, rt2_tag_count, rt2_tag_match;
  logic master_reset_pin, term_one_enable_pin, term_two_enable_pin;
  logic [5:0] term_one_addr_pins, term_two_addr_pins, term_one_op_status, term_two_op_status;
  int fails;
  int comparisons;

  hwil_top u_dut (.clk_sys, .arst_n, .reg_sel, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rd_valid, .bc_tag_tick, .bc_tag_wide, .bc_tag_count, .bc_tag_match, .mt_tag_tick,
    .mt_tag_wide, .mt_tag_count, .mt_tag_match, .rt1_tag_tick, .rt1_tag_count,
    .rt1_tag_match, .rt2_tag_tick, .rt2_tag_count, .rt2_tag_match, .bc_pend_reg,
    .mt_pend_reg, .rt_pend_reg, .master_reset_pin, .term_one_enable_pin,
    .term_two_enable_pin, .term_one_addr_pins, .term_two_addr_pins, .hw_int_out,
    .term_one_op_status, .term_two_op_status);

  hwil_host_model u_host (.clk_sys, .reg_sel, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rd_valid);

  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic rd_chk(input string name, input logic [1:0] sel, input logic [15:0] exp);
    logic [15:0] d;
    bit ok;
    u_host.rd(sel, d, ok);
    if (!ok) begin
      fails++;
      $display("[FAIL] %s expected read answer seen none", name);
      print_verdict();
    end else begin
      `CHK(name, exp, d)
    end
  endtask : rd_chk

  // Tick every counter at once; only the chosen one hits
  task automatic fire(input int b);
    @(posedge clk_sys);
    case (b)
      9: bc_tag_count <= 32'h12340000;
      8: rt2_tag_count <= 16'h0002;
      7: rt1_tag_count <= 16'h0002;
      6: mt_tag_count <= 48'h000100000002;
      default: bc_tag_count <= 32'h00000002;
    endcase
    bc_tag_tick <= 1'b1;
    mt_tag_tick <= 1'b1;
    rt1_tag_tick <= 1'b1;
    rt2_tag_tick <= 1'b1;
    @(posedge clk_sys);
    bc_tag_tick <= 1'b0;
    mt_tag_tick <= 1'b0;
    rt1_tag_tick <= 1'b0;
    rt2_tag_tick <= 1'b0;
    bc_tag_count <= 32'h00000001;
    mt_tag_count <= 48'h000000000001;
    rt1_tag_count <= 16'h0001;
    rt2_tag_count <= 16'h0001;
  endtask : fire

  task automatic test_regs();
    rd_chk("pend reset", hwil_pkg::HWIL_REG_PEND, 16'h0018);
    rd_chk("en reset", hwil_pkg::HWIL_REG_EN, 16'h0018);
    rd_chk("oen reset", hwil_pkg::HWIL_REG_OEN, 16'h0000);
    u_host.wr(2'h3, 16'hFFFF);
    rd_chk("unmapped", 2'h3, 16'h0000);
    u_host.wr(hwil_pkg::HWIL_REG_EN, 16'hFFFF);
    u_host.wr(hwil_pkg::HWIL_REG_OEN, 16'hFFFF);
    rd_chk("en mask", hwil_pkg::HWIL_REG_EN, 16'h03F8);
    rd_chk("oen mask", hwil_pkg::HWIL_REG_OEN, 16'h03F8);
    `CHK("reset flags int", 1'b1, hw_int_out)
    u_host.wr(hwil_pkg::HWIL_REG_PEND, 16'hFFFF);
    @(posedge clk_sys);
    #1;
    `CHK("flags cleared int", 1'b0, hw_int_out)
    rd_chk("pend cleared", hwil_pkg::HWIL_REG_PEND, 16'h0000);
    $display("test regs done");
  endtask : test_regs

  task automatic test_summary();
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      bc_pend_reg <= (k == 0) ? 16'h8000 : 16'h0000;
      mt_pend_reg <= (k == 1) ? 16'h0001 : 16'h0000;
      rt_pend_reg <= (k == 2) ? 16'h0100 : 16'h0000;
      rd_chk("summary", hwil_pkg::HWIL_REG_PEND, 16'h0001 << k);
      `CHK("summary no int", 1'b0, hw_int_out)
    end
    @(posedge clk_sys);
    rt_pend_reg <= 16'h0000;
    rd_chk("summary idle", hwil_pkg::HWIL_REG_PEND, 16'h0000);
    $display("test summary done");
  endtask : test_summary

  task automatic test_events();
    logic [15:0] m;
    for (int b = 5; b <= 9; b++) begin
      m = 16'h0001 << b;
      u_host.wr(hwil_pkg::HWIL_REG_EN, 16'h0000);
      u_host.wr(hwil_pkg::HWIL_REG_OEN, m);
      u_host.wr(hwil_pkg::HWIL_REG_PEND, 16'hFFFF);
      fire(b);
      rd_chk("dropped event", hwil_pkg::HWIL_REG_PEND, 16'h0000);
      u_host.wr(hwil_pkg::HWIL_REG_EN, m);
      fire(b);
      @(posedge clk_sys);
      #1;
      `CHK("event int", 1'b1, hw_int_out)
      rd_chk("event pending", hwil_pkg::HWIL_REG_PEND, m);
      // Clear and a new event on the same edge: the event must survive
      fork
        u_host.wr(hwil_pkg::HWIL_REG_PEND, m);
        fire(b);
      join
      rd_chk("set beats clear", hwil_pkg::HWIL_REG_PEND, m);
      u_host.wr(hwil_pkg::HWIL_REG_PEND, m);
      @(posedge clk_sys);
      #1;
      `CHK("cleared int", 1'b0, hw_int_out)
    end
    // Wide counters use every bit: no 16-bit wrap or match
    @(posedge clk_sys);
    bc_tag_wide <= 1'b1;
    mt_tag_wide <= 1'b1;
    u_host.wr(hwil_pkg::HWIL_REG_EN, 16'h0260);
    fire(9);
    fire(6);
    rd_chk("wide no wrap", hwil_pkg::HWIL_REG_PEND, 16'h0000);
    fire(5);
    rd_chk("wide match", hwil_pkg::HWIL_REG_PEND, 16'h0020);
    u_host.wr(hwil_pkg::HWIL_REG_PEND, 16'hFFFF);
    @(posedge clk_sys);
    bc_tag_wide <= 1'b0;
    mt_tag_wide <= 1'b0;
    $display("test events done");
  endtask : test_events

  task automatic mr_pulse(input logic e1, e2, input logic [5:0] a1, a2);
    logic [15:0] exp;
    exp = {11'h000, e2 & ~(^a2), e1 & ~(^a1), 3'h0};
    @(posedge clk_sys);
    master_reset_pin <= 1'b0;
    term_one_enable_pin <= e1;
    term_two_enable_pin <= e2;
    term_one_addr_pins <= a1;
    term_two_addr_pins <= a2;
    repeat (6) @(posedge clk_sys);
    master_reset_pin <= 1'b1;
    // Three filter stages, capture, then pending load
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK("op status one", a1, term_one_op_status)
    `CHK("op status two", a2, term_two_op_status)
    rd_chk("parity flags", hwil_pkg::HWIL_REG_PEND, exp);
  endtask : mr_pulse

  task automatic test_parity();
    u_host.wr(hwil_pkg::HWIL_REG_EN, 16'h0018);
    mr_pulse(1'b1, 1'b1, 6'h01, 6'h03);
    mr_pulse(1'b1, 1'b1, 6'h00, 6'h07);
    mr_pulse(1'b0, 1'b0, 6'h00, 6'h03);
    $display("test parity done");
  endtask : test_parity

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    fails = 0;
    comparisons = 0;
    arst_n = 1'b0;
    {bc_tag_tick, bc_tag_wide, mt_tag_tick, mt_tag_wide, rt1_tag_tick, rt2_tag_tick} = 6'h00;
    bc_tag_count = 32'h00000001;
    bc_tag_match = 32'h00000002;
    mt_tag_count = 48'h000000000001;
    mt_tag_match = 48'h000000000002;
    rt1_tag_count = 16'h0001;
    rt1_tag_match = 16'h0002;
    rt2_tag_count = 16'h0001;
    rt2_tag_match = 16'h0002;
    {bc_pend_reg, mt_pend_reg, rt_pend_reg} = 48'h000000000000;
    {master_reset_pin, term_one_enable_pin, term_two_enable_pin} = 3'h0;
    term_one_addr_pins = 6'h00;
    term_two_addr_pins = 6'h00;
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    test_regs();
    test_summary();
    test_events();
    test_parity();
    print_verdict();
  end
endmodule : hwil_top_tb
